// ==== rtl/mps_sequencer.sv ====
// Power on, power off and reset sequencer of the module
`timescale 1ns/1ps
module mps_sequencer #(
    parameter logic [mps_pkg::CNT_W-1:0] ON_HOLD_CYCLES = mps_pkg::CNT_W'(mps_pkg::ON_HOLD_CYC),
    parameter logic [mps_pkg::CNT_W-1:0] OFF_HOLD_CYCLES = mps_pkg::CNT_W'(mps_pkg::OFF_HOLD_CYC),
    parameter logic [mps_pkg::CNT_W-1:0] RST_HOLD_CYCLES = mps_pkg::CNT_W'(mps_pkg::RST_HOLD_CYC)
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic power_key_n,
    input wire logic reset_n,
    input wire logic shutdown_command,
    input wire logic shutdown_done,
    output logic power_on,
    output logic core_reset,
    output logic shutdown_req,
    output logic power_down_done
);
    mps_pkg::mps_state_t state_q;
    mps_pkg::mps_state_t state_d;
    logic key_low;
    logic key_on_held;
    logic key_off_held;
    logic rst_low;
    logic rst_held;
    logic rst_armed_q;
    logic rst_armed_d;
    logic off_armed_q;
    logic off_armed_d;
    logic core_reset_q;
    logic power_on_q;
    logic shutdown_req_q;
    logic done_q;

    ////////////////////////////////////////////////////////////////////////
    // Line timers
    mps_low_timer u_key_on (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .line_n(power_key_n),
        .limit(ON_HOLD_CYCLES),
        .low(key_low),
        .held(key_on_held)
    );

    mps_low_timer u_key_off (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .line_n(power_key_n),
        .limit(OFF_HOLD_CYCLES),
        .low(),
        .held(key_off_held)
    );

    mps_low_timer u_rst (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .line_n(reset_n),
        .limit(RST_HOLD_CYCLES),
        .low(rst_low),
        .held(rst_held)
    );

    ////////////////////////////////////////////////////////////////////////
    // Press arming
    wire rst_release = rst_armed_q && !rst_low;
    wire key_release = off_armed_q && !key_low;
    assign rst_armed_d = rst_held ? 1'b1 : (rst_low ? rst_armed_q : 1'b0);
    wire in_run = state_q == mps_pkg::ST_RUN;
    assign off_armed_d = (in_run && key_off_held) ? 1'b1 : (key_low ? off_armed_q : 1'b0);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rst_armed_q <= 1'b0;
            off_armed_q <= 1'b0;
        end else begin
            rst_armed_q <= rst_armed_d;
            off_armed_q <= off_armed_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State machine
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            mps_pkg::ST_OFF: begin
                if (key_on_held) begin
                    state_d = mps_pkg::ST_BOOT;
                end
            end
            mps_pkg::ST_BOOT: begin
                state_d = mps_pkg::ST_KEY_WAIT;
            end
            mps_pkg::ST_KEY_WAIT: begin
                if (shutdown_command) begin
                    state_d = mps_pkg::ST_SHUT;
                end else if (!key_low) begin
                    state_d = mps_pkg::ST_RUN;
                end
            end
            mps_pkg::ST_RUN: begin
                if (shutdown_command || key_release) begin
                    state_d = mps_pkg::ST_SHUT;
                end
            end
            mps_pkg::ST_SHUT: begin
                if (shutdown_done) begin
                    state_d = mps_pkg::ST_OFF;
                end
            end
            default: begin
                state_d = mps_pkg::ST_OFF;
            end
        endcase
    end

    function automatic logic powered(input mps_pkg::mps_state_t st);
        return st != mps_pkg::ST_OFF;
    endfunction

    wire running = powered(state_d);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= mps_pkg::ST_OFF;
            power_on_q <= 1'b0;
            core_reset_q <= 1'b1;
            shutdown_req_q <= 1'b0;
            done_q <= 1'b1;
        end else begin
            state_q <= state_d;
            power_on_q <= running;
            core_reset_q <= !running || rst_low || state_d == mps_pkg::ST_BOOT;
            shutdown_req_q <= state_d == mps_pkg::ST_SHUT;
            done_q <= state_d == mps_pkg::ST_OFF;
        end
    end

    assign power_on = power_on_q;
    assign core_reset = core_reset_q;
    assign shutdown_req = shutdown_req_q;
    assign power_down_done = done_q;

    ////////////////////////////////////////////////////////////////////////
    // Check helpers
    logic [mps_pkg::CNT_W-1:0] low_run_q;
    logic [mps_pkg::CNT_W-1:0] low_run_d;
    wire low_run_full = &low_run_q;
    assign low_run_d = !key_low ? '0 : (low_run_full ? low_run_q : low_run_q + 1'b1);

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_run_q <= '0;
        end else begin
            low_run_q <= low_run_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    AST_ON_NEEDS_HOLD: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state_q == mps_pkg::ST_BOOT) |-> $past(key_on_held))
        else $error("Start without full key hold");
    AST_OFF_ON_RELEASE: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_RUN && key_release && !shutdown_command) |=> state_q == mps_pkg::ST_SHUT)
        else $error("Key release did not start shutdown");
    AST_CMD_SHUTS: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_RUN && shutdown_command) |=> ##1 shutdown_req)
        else $error("Command did not raise shutdown request");
    AST_DONE_ONLY_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
        power_down_done |-> !power_on)
        else $error("Done while powered");
    AST_TIED_KEY_BOOTS: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_OFF && key_on_held) |=> ##1 power_on)
        else $error("Held key did not power up");
    AST_RST_HOLDS: assert property (@(posedge core_clk) disable iff (sys_rst)
        (rst_low && power_on) |=> core_reset)
        else $error("Reset line low but core not in reset");
    AST_SHUT_WAITS: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_SHUT && !shutdown_done) |=> state_q == mps_pkg::ST_SHUT)
        else $error("Shutdown left without completion");
    AST_RST_RELEASE_ARMED: assert property (@(posedge core_clk) disable iff (sys_rst)
        rst_release |-> $past(rst_held, 2) || $past(rst_armed_q))
        else $error("Reset release without full hold");
    AST_ON_FULL_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
        $rose(state_q == mps_pkg::ST_BOOT) |-> $past(low_run_q) >= ON_HOLD_CYCLES)
        else $error("Start before the key was low long enough");
    AST_OFF_FULL_COUNT: assert property (@(posedge core_clk) disable iff (sys_rst)
        key_release |-> low_run_q >= OFF_HOLD_CYCLES)
        else $error("Off release before the key was low long enough");
    AST_BOOT_IN_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_BOOT) |-> core_reset)
        else $error("Core out of reset during boot");
    AST_SHORT_PRESS_IGNORED: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_OFF && !key_on_held) |=> state_q == mps_pkg::ST_OFF)
        else $error("Left power down without full key hold");
    AST_ON_PRESS_KEEPS_ON: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_KEY_WAIT && !shutdown_command) |=> (power_on && !shutdown_req))
        else $error("Turn on press also turned the module off");
    AST_TIED_STAYS_ON: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_KEY_WAIT && key_low && !shutdown_command) |=> state_q == mps_pkg::ST_KEY_WAIT)
        else $error("Held key left the wait for release");
    AST_DONE_POWERS_OFF: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_SHUT && shutdown_done) |=> (power_down_done && !power_on && core_reset))
        else $error("Completed shutdown did not power down");
    AST_POWER_FOLLOWS_STATE: assert property (@(posedge core_clk) disable iff (sys_rst)
        power_on == powered(state_q))
        else $error("Power output disagrees with state");
    AST_RUN_OUT_OF_RESET: assert property (@(posedge core_clk) disable iff (sys_rst)
        (state_q == mps_pkg::ST_RUN && state_d == mps_pkg::ST_RUN && !rst_low) |=> !core_reset)
        else $error("Core held in reset after reset line release");
    AST_REQ_ONLY_SHUT: assert property (@(posedge core_clk) disable iff (sys_rst)
        shutdown_req |-> state_q == mps_pkg::ST_SHUT)
        else $error("Shutdown request outside shutdown");
endmodule

// ==== rtl/mps_pkg.sv ====
// Package with timing constants and state codes for the power sequencer
package mps_pkg;
    localparam int unsigned CLK_PERIOD_PS = 4000;
    localparam longint unsigned ON_HOLD_MS = 2000;
    localparam longint unsigned OFF_HOLD_MS = 3000;
    localparam longint unsigned RST_HOLD_MS = 100;
    localparam longint unsigned PS_PER_MS = 1000000000;
    localparam longint unsigned ON_HOLD_CYC = (ON_HOLD_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned OFF_HOLD_CYC = (OFF_HOLD_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam longint unsigned RST_HOLD_CYC = (RST_HOLD_MS * PS_PER_MS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned CNT_W = 30;
    localparam logic [1:0] SYNC_RST_VAL = 2'h3;

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_BOOT = 3'b001,
        ST_RUN = 3'b010,
        ST_KEY_WAIT = 3'b011,
        ST_SHUT = 3'b100
    } mps_state_t;
endpackage

// ==== rtl/mps_low_timer.sv ====
// Synchroniser and low-time counter for one active-low input line
`timescale 1ns/1ps
module mps_low_timer (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic line_n,
    input wire logic [mps_pkg::CNT_W-1:0] limit,
    output logic low,
    output logic held
);
    logic [1:0] sync_q;
    logic [mps_pkg::CNT_W-1:0] cnt_q;
    logic [mps_pkg::CNT_W-1:0] cnt_d;
    wire line_low = ~sync_q[1];
    wire at_limit = cnt_q >= limit;

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync_q <= mps_pkg::SYNC_RST_VAL;
        end else begin
            sync_q <= {sync_q[0], line_n};
        end
    end

    always_comb begin
        if (!line_low) begin
            cnt_d = '0;
        end else if (at_limit) begin
            cnt_d = cnt_q;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign low = line_low;
    assign held = line_low && at_limit;
endmodule

// ==== test/mps_host.sv ====
// Host controller model driving the key and reset lines
`timescale 1ns/1ps
module mps_host (
    output logic power_key_n,
    output logic reset_n,
    input wire logic core_clk
);
    initial begin
        power_key_n = 1'b1;
        reset_n = 1'b1;
    end
    // Key held low n cycles, then released high
    task automatic press(input int n);
        @(negedge core_clk) power_key_n = 1'b0;
        repeat (n) @(negedge core_clk);
        power_key_n = 1'b1;
    endtask
    // Reset line held low n cycles, then released high
    task automatic pulse_rst(input int n);
        @(negedge core_clk) reset_n = 1'b0;
        repeat (n) @(negedge core_clk);
        reset_n = 1'b1;
    endtask
    // Key tied to a fixed level
    task automatic tie(input logic v);
        power_key_n = v;
    endtask
endmodule

// ==== test/mps_sequencer_bench.sv ====
// Testbench of the power sequencer
`timescale 1ns/1ps
module mps_sequencer_bench;
    localparam logic [mps_pkg::CNT_W-1:0] ON_CYC = 30'h0000_0014;
    localparam logic [mps_pkg::CNT_W-1:0] OFF_CYC = 30'h0000_001e;
    localparam logic [mps_pkg::CNT_W-1:0] RST_CYC = 30'h0000_0005;
    logic core_clk = 1'b0;
    logic sys_rst;
    logic shutdown_command;
    logic shutdown_done;
    logic power_key_n, reset_n, power_on, core_reset, shutdown_req, power_down_done;
    int fails = 0;
    int n_checks = 0;
    int cyc = 0;
    int rows [4][3] = '{'{10, 0, 0}, '{25, 1, 0}, '{20, 1, 0}, '{40, 1, 1}};
    mps_host u_host (.power_key_n(power_key_n), .reset_n(reset_n), .core_clk(core_clk));
    mps_sequencer #(.ON_HOLD_CYCLES(ON_CYC), .OFF_HOLD_CYCLES(OFF_CYC), .RST_HOLD_CYCLES(RST_CYC)) u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .power_key_n(power_key_n), .reset_n(reset_n),
        .shutdown_command(shutdown_command), .shutdown_done(shutdown_done), .power_on(power_on),
        .core_reset(core_reset), .shutdown_req(shutdown_req), .power_down_done(power_down_done));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            fails = fails + 1;
            report_and_stop();
        end
    end
    task automatic chk(input logic got, input logic exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error at %0t: got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    task automatic finish_shut();
        shutdown_done = 1'b1;
        wt(3);
        chk(power_down_done, 1'b1);
        chk(power_on, 1'b0);
        shutdown_done = 1'b0;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        sys_rst = 1'b1;
        shutdown_command = 1'b0;
        shutdown_done = 1'b0;
        wt(6);
        sys_rst = 1'b0;
        chk(power_down_done, 1'b1);
        wt(8);
        for (int i = 0; i < 4; i++) begin
            u_host.press(rows[i][0]);
            wt(6);
            chk(power_on, rows[i][1][0]);
            chk(shutdown_req, rows[i][2][0]);
            $display("row %0d done", i);
        end
        wt(17);
        finish_shut();
        $display("key shutdown done");
        u_host.press(25);
        wt(6);
        chk(core_reset, 1'b0);
        @(negedge core_clk) shutdown_command = 1'b1;
        @(negedge core_clk) shutdown_command = 1'b0;
        wt(2);
        chk(shutdown_req, 1'b1);
        chk(power_on, 1'b1);
        wt(20);
        finish_shut();
        $display("command shutdown done");
        fork
            u_host.press(25);
            begin
                wt(24);
                shutdown_command = 1'b1;
                wt(2);
                shutdown_command = 1'b0;
            end
        join
        chk(shutdown_req, 1'b1);
        wt(3);
        finish_shut();
        $display("early command done");
        u_host.press(25);
        wt(6);
        fork
            u_host.pulse_rst(30);
            begin
                wt(10);
                chk(core_reset, 1'b1);
                chk(power_on, 1'b1);
            end
        join
        wt(4);
        chk(core_reset, 1'b0);
        chk(power_on, 1'b1);
        $display("reset pulse done");
        sys_rst = 1'b1;
        u_host.tie(1'b0);
        wt(2);
        sys_rst = 1'b0;
        wt(40);
        chk(power_on, 1'b1);
        wt(40);
        chk(power_on, 1'b1);
        chk(shutdown_req, 1'b0);
        u_host.tie(1'b1);
        $display("tied key done");
        report_and_stop();
    end
endmodule
